// ---- usb_status_control_map.svh ----
`ifndef USB_STATUS_CONTROL_MAP_SVH
`define USB_STATUS_CONTROL_MAP_SVH
// Register byte offsets on the plain register port.
`define OFS_LAST_TRANSFER_STATUS 8'h00
`define OFS_BUS_CONTROL 8'h04
`define OFS_DEVICE_ADDRESS_SPEED 8'h08
`define OFS_TRANSFER_DONE 8'h0C
// Field positions in the status register.
`define STAT_ENDP_HI 7
`define STAT_ENDP_LO 4
`define STAT_DIR_BIT 3
`define STAT_BANK_BIT 2
// Field positions in the control register.
`define CON_LIVE_J_STATE_BIT 7
`define CON_SE0_BIT 6
`define CON_PACKET_PROCESSING_DISABLE_BIT 5
`define CON_BUSRST_BIT 4
`define CON_HOST_MODE_ENABLE_BIT 3
`define CON_RESUME_BIT 2
`define CON_PPRST_BIT 1
`define CON_ENABLE_BIT 0
// Field positions in the address register.
`define ADDR_LOWSPEED_BIT 7
// Reset values.
`define RST_BUS_CONTROL 6'h00
`define RST_DEVICE_ADDRESS 8'h00
// Timing: frame period in milliseconds and clock rate in MHz.
`define FRAME_PERIOD_US 1
`define CLK_MHZ 100
`define FRAME_CYCLES (`FRAME_PERIOD_US * 1000 * `CLK_MHZ)
// Length of the low-speed end-of-packet appended to resume, in nanoseconds and in cycles.
`define LS_EOP_NS 1330
`define LS_EOP_CYCLES ((`LS_EOP_NS + 9) / 10)
// Depth of the status FIFO.
`define STAT_FIFO_DEPTH 4
`endif

// ---- usb_status_control_pkg.sv ----
package usb_status_control_pkg;
  // One status FIFO entry.
  typedef struct packed {
    logic [3:0] endpoint;
    logic dir;
    logic bank;
  } stat_entry_s;
  // Token codes a host writes to the token command register.
  typedef enum logic [3:0] {
    TOK_OUT = 4'h1,
    TOK_IN = 4'h9,
    TOK_SETUP = 4'hD
  } token_e;
  // Resume sequencing in host mode.
  typedef enum logic [1:0] {RES_IDLE, RES_ACTIVE, RES_EOP} resume_e;
  // Plain register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  // Line state sampled from the bus.
  typedef struct packed {
    logic live_j_state;
    logic se0;
  } line_s;
endpackage

// ---- usb_status_control.sv ----
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "usb_status_control_map.svh"
// Notes on behaviour
// - Status bits 7..4 give last endpoint.
// - Status bit 3 gives transfer direction.
// - Status bit 2 gives odd or even bank.
// - Status reads head of four-entry FIFO.
// - Clearing done flag advances status FIFO.
// - Upper bits and status bits 1..0 read zero.
// - Control bit 7 shows live J state.
// - Control bit 6 shows live SE0.
// - Device mode bit 5 disables packets; SETUP sets.
// - Host mode bit 5 shows token busy.
// - Host mode bit 4 drives bus reset.
// - Bit 3 enables host; toggle resets host.
// - Bit 2 resumes; host appends low-speed EOP.
// - Bit 1 forces ping-pong pointers even.
// - Device mode bit 0 enables module.
// - Host mode bit 0 sends SOF each ms.
// - Address bit 7 selects low speed.
// - Address bits 6..0 hold device address.
module usb_status_control (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Register port.
  input wire usb_status_control_pkg::reg_req_s regReq,
  output logic [31:0] regRdata,
  // Live line state from the transceiver pins.
  input wire usb_status_control_pkg::line_s linePins,
  // Transaction completion from the packet engine.
  input wire logic txnDone,
  input wire usb_status_control_pkg::stat_entry_s txnStat,
  input wire logic setupRcvd,
  input wire logic tokenActive,
  // Controls toward the packet engine and line driver.
  output logic moduleEnable,
  output logic hostMode,
  output logic hostLogicReset,
  output logic packetDisable,
  output logic busResetDrive,
  output logic resumeDrive,
  output logic lsEopDrive,
  output logic pingpongReset,
  output logic sofPulse,
  output logic lowSpeedSelect,
  output logic [6:0] deviceAddress,
  output logic transferDone
);
  localparam int FrameCycles = `FRAME_CYCLES;
  localparam int EopCycles = `LS_EOP_CYCLES;
  localparam int Depth = `STAT_FIFO_DEPTH;

  typedef struct packed {
    logic [2:0] jSync;
    logic [2:0] seSync;
    logic live_j_state;
    logic se0;
    logic [1:0] rdPtr;
    logic [1:0] wrPtr;
    logic [2:0] count;
    logic [5:0] ctrl;
    logic [7:0] addr;
    logic [16:0] frameCnt;
    logic [7:0] eopCnt;
    usb_status_control_pkg::resume_e resState;
    logic sof;
    logic hostRst;
    logic [31:0] rdata;
  } state_s;

  state_s cur;
  state_s next_cur;
  usb_status_control_pkg::stat_entry_s fifoMem [Depth];
  usb_status_control_pkg::stat_entry_s head;
  logic push;
  logic pop;
  logic [5:0] wctrl;

  // The FIFO storage lives outside the state struct since arrays are awkward
  // inside packed structs; its pointers live in the struct.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifoMem[cur.wrPtr] <= txnStat;
    end
  end

  assign head = fifoMem[cur.rdPtr];

  // Next-state logic for all control state.
  always_comb begin
    next_cur = cur;
    wctrl = regReq.wdata[5:0];
    // Three-stage synchronisers; a level counts once stages two and three agree.
    next_cur.jSync = {cur.jSync[1:0], linePins.live_j_state};
    next_cur.seSync = {cur.seSync[1:0], linePins.se0};
    if (cur.jSync[2] == cur.jSync[1]) begin
      next_cur.live_j_state = cur.jSync[2];
    end
    if (cur.seSync[2] == cur.seSync[1]) begin
      next_cur.se0 = cur.seSync[2];
    end
    // A full FIFO drops new entries rather than overwrite unread status.
    push = txnDone && (cur.count != 3'(Depth));
    pop = regReq.wr && (regReq.addr == `OFS_TRANSFER_DONE) &&
      regReq.wdata[0] && (cur.count != 3'h0);
    if (push) begin
      next_cur.wrPtr = cur.wrPtr + 2'h1;
    end
    if (pop) begin
      next_cur.rdPtr = cur.rdPtr + 2'h1;
    end
    next_cur.count = cur.count + 3'(push) - 3'(pop);
    // Register writes.
    if (regReq.wr && regReq.addr == `OFS_BUS_CONTROL) begin
      next_cur.ctrl = wctrl;
    end
    if (regReq.wr && regReq.addr == `OFS_DEVICE_ADDRESS_SPEED) begin
      next_cur.addr = regReq.wdata[7:0];
    end
    // A SETUP in device mode sets packet disable after any write, so it wins.
    if (!cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] && setupRcvd) begin
      next_cur.ctrl[`CON_PACKET_PROCESSING_DISABLE_BIT] = 1'b1;
    end
    // Any toggle of host enable resets host logic for one cycle.
    next_cur.hostRst = next_cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] !=
      cur.ctrl[`CON_HOST_MODE_ENABLE_BIT];
    // Start-of-frame timer runs only while host SOF generation is on.
    next_cur.sof = 1'b0;
    if (!(cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] && cur.ctrl[`CON_ENABLE_BIT]) ||
        cur.hostRst) begin
      next_cur.frameCnt = 17'h00000;
    end else if (cur.frameCnt == 17'(FrameCycles - 1)) begin
      next_cur.frameCnt = 17'h00000;
      next_cur.sof = 1'b1;
    end else begin
      next_cur.frameCnt = cur.frameCnt + 17'h00001;
    end
    // Resume: on release in host mode, append a low-speed EOP.
    unique case (cur.resState)
      usb_status_control_pkg::RES_IDLE: begin
        if (cur.ctrl[`CON_RESUME_BIT]) begin
          next_cur.resState = usb_status_control_pkg::RES_ACTIVE;
        end
      end
      usb_status_control_pkg::RES_ACTIVE: begin
        if (!cur.ctrl[`CON_RESUME_BIT]) begin
          next_cur.eopCnt = 8'h00;
          next_cur.resState = cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] ?
            usb_status_control_pkg::RES_EOP :
            usb_status_control_pkg::RES_IDLE;
        end
      end
      usb_status_control_pkg::RES_EOP: begin
        next_cur.eopCnt = cur.eopCnt + 8'h01;
        if (cur.eopCnt == 8'(EopCycles - 1)) begin
          next_cur.resState = usb_status_control_pkg::RES_IDLE;
        end
      end
    endcase
    if (cur.hostRst && cur.resState == usb_status_control_pkg::RES_EOP) begin
      next_cur.resState = usb_status_control_pkg::RES_IDLE;
    end
    // Read data stands in the cycle after the read strobe only.
    next_cur.rdata = 32'h00000000;
    if (regReq.rd) begin
      unique case (regReq.addr)
        `OFS_LAST_TRANSFER_STATUS: begin
          next_cur.rdata[`STAT_ENDP_HI:`STAT_ENDP_LO] = head.endpoint;
          next_cur.rdata[`STAT_DIR_BIT] = head.dir;
          next_cur.rdata[`STAT_BANK_BIT] = head.bank;
        end
        `OFS_BUS_CONTROL: begin
          next_cur.rdata[5:0] = cur.ctrl;
          if (cur.ctrl[`CON_HOST_MODE_ENABLE_BIT]) begin
            next_cur.rdata[`CON_PACKET_PROCESSING_DISABLE_BIT] = tokenActive;
          end
          next_cur.rdata[`CON_LIVE_J_STATE_BIT] = cur.live_j_state;
          next_cur.rdata[`CON_SE0_BIT] = cur.se0;
        end
        `OFS_DEVICE_ADDRESS_SPEED: begin
          next_cur.rdata[7:0] = cur.addr;
        end
        `OFS_TRANSFER_DONE: begin
          next_cur.rdata[0] = cur.count != 3'h0;
        end
        default: begin
          next_cur.rdata = 32'h00000000;
        end
      endcase
    end
    if (srst) begin
      next_cur = '0;
      next_cur.ctrl = `RST_BUS_CONTROL;
      next_cur.addr = `RST_DEVICE_ADDRESS;
      next_cur.resState = usb_status_control_pkg::RES_IDLE;
    end
  end

  // Single state register.
  always_ff @(posedge clk_sys) begin
    cur <= next_cur;
  end

  // Outputs decoded from registered state.
  assign regRdata = cur.rdata;
  assign hostMode = cur.ctrl[`CON_HOST_MODE_ENABLE_BIT];
  assign hostLogicReset = cur.hostRst;
  assign moduleEnable = !cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] &&
    cur.ctrl[`CON_ENABLE_BIT];
  assign packetDisable = !cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] &&
    cur.ctrl[`CON_PACKET_PROCESSING_DISABLE_BIT];
  assign busResetDrive = cur.ctrl[`CON_HOST_MODE_ENABLE_BIT] &&
    cur.ctrl[`CON_BUSRST_BIT];
  assign resumeDrive = cur.ctrl[`CON_RESUME_BIT];
  assign lsEopDrive = cur.resState == usb_status_control_pkg::RES_EOP;
  assign pingpongReset = cur.ctrl[`CON_PPRST_BIT];
  assign sofPulse = cur.sof;
  assign lowSpeedSelect = cur.addr[`ADDR_LOWSPEED_BIT];
  assign deviceAddress = cur.addr[6:0];
  assign transferDone = cur.count != 3'h0;
endmodule

// ---- usb_status_control_sva.sv ----
`timescale 1ns/10ps
module usb_status_control_sva (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Watched ports.
  input wire usb_status_control_pkg::reg_req_s regReq,
  input wire logic [31:0] regRdata,
  input wire logic txnDone,
  input wire logic transferDone,
  input wire logic hostMode,
  input wire logic hostLogicReset,
  input wire logic packetDisable,
  input wire logic moduleEnable,
  input wire logic busResetDrive,
  input wire logic resumeDrive,
  input wire logic lsEopDrive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Resume released while the host side owns the bus.
  sequence resumeEnd_s;
    $fell(resumeDrive) && hostMode;
  endsequence
  ls_eop_a: assert property (resumeEnd_s |-> ##[0:2] lsEopDrive)
    else $error("no end of packet after resume");
  rd_idle_a: assert property (!$past(regReq.rd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  hi_zero_a: assert property (regRdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  host_rst_a: assert property ($changed(hostMode) |-> ##[0:1] hostLogicReset)
    else $error("no host logic reset on mode change");
  rst_pulse_a: assert property (hostLogicReset |=> !hostLogicReset)
    else $error("host logic reset too long");
  done_push_a: assert property (txnDone && !transferDone |=> transferDone)
    else $error("done flag missing after push");
  dev_only_a: assert property (packetDisable || moduleEnable |-> !hostMode)
    else $error("device control in host mode");
  host_only_a: assert property (busResetDrive |-> hostMode)
    else $error("bus reset outside host mode");
endmodule
bind usb_status_control usb_status_control_sva chk_u (.clk_sys(clk_sys),
  .srst(srst), .regReq(regReq), .regRdata(regRdata), .txnDone(txnDone),
  .transferDone(transferDone), .hostMode(hostMode),
  .hostLogicReset(hostLogicReset), .packetDisable(packetDisable),
  .moduleEnable(moduleEnable), .busResetDrive(busResetDrive),
  .resumeDrive(resumeDrive), .lsEopDrive(lsEopDrive));

// ---- usb_far_end.sv ----
`timescale 1ns/10ps
module usb_far_end (
  // Drives seen on the bus.
  input wire logic busResetDrive,
  input wire logic resumeDrive,
  input wire logic lsEopDrive,
  // Line state back to the transceiver pins.
  output usb_status_control_pkg::line_s linePins
);
  // The pull-up holds J when idle; reset and EOP give SE0, resume gives K.
  assign linePins.se0 = busResetDrive | lsEopDrive;
  assign linePins.live_j_state = !(linePins.se0 | resumeDrive);
endmodule

// ---- test_usb_status_control.sv ----
`timescale 1ns/10ps
module test_usb_status_control;
  logic clk_sys = 0, srst = 1, txnDone = 0, setupRcvd = 0, tokenActive = 0;
  usb_status_control_pkg::reg_req_s regReq = '0;
  usb_status_control_pkg::stat_entry_s txnStat = '0;
  usb_status_control_pkg::line_s linePins;
  logic [31:0] regRdata;
  logic moduleEnable, hostMode, hostLogicReset, packetDisable, busResetDrive;
  logic resumeDrive, lsEopDrive, pingpongReset, sofPulse, lowSpeedSelect;
  logic transferDone;
  logic [6:0] deviceAddress;
  int bad_count = 0, total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  usb_status_control dut_u (.clk_sys(clk_sys), .srst(srst), .regReq(regReq),
    .regRdata(regRdata), .linePins(linePins), .txnDone(txnDone),
    .txnStat(txnStat), .setupRcvd(setupRcvd), .tokenActive(tokenActive),
    .moduleEnable(moduleEnable), .hostMode(hostMode),
    .hostLogicReset(hostLogicReset), .packetDisable(packetDisable),
    .busResetDrive(busResetDrive), .resumeDrive(resumeDrive),
    .lsEopDrive(lsEopDrive), .pingpongReset(pingpongReset),
    .sofPulse(sofPulse), .lowSpeedSelect(lowSpeedSelect),
    .deviceAddress(deviceAddress), .transferDone(transferDone));
  usb_far_end far_u (.busResetDrive(busResetDrive), .resumeDrive(resumeDrive),
    .lsEopDrive(lsEopDrive), .linePins(linePins));
  // Counts every compare so an empty run cannot pass.
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys) regReq <= '0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys) regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys) regReq <= '0;
    #1 chk(regRdata, e);
  endtask
  task t_regs;
    rd(8'h08, 32'h0);
    wr(8'h08, 32'hFFFFFFD5);
    rd(8'h08, 32'hD5);
    chk(lowSpeedSelect, 1);
    chk(deviceAddress, 7'h55);
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h0);
  endtask
  // Five back-to-back pushes: the fifth finds the queue full.
  task t_fifo;
    logic [3:0] i;
    for (i = 0; i < 5; i++) begin
      @(posedge clk_sys) txnDone <= 1;
      txnStat <= '{4'hF - i, i[0], ~i[0]};
    end
    @(posedge clk_sys) txnDone <= 0;
    for (i = 0; i < 4; i++) begin
      rd(8'h0C, 32'h1);
      rd(8'h00, {24'h0, 4'hF - i, i[0], ~i[0], 2'b00});
      wr(8'h0C, 32'h1);
    end
    @(posedge clk_sys) #1 chk(transferDone, 0);
  endtask
  task t_dev;
    wr(8'h04, 32'h01);
    @(posedge clk_sys) setupRcvd <= 1;
    @(posedge clk_sys) setupRcvd <= 0;
    repeat (2) @(posedge clk_sys);
    #1 chk(moduleEnable, 1);
    rd(8'h04, 32'hA1);
    wr(8'h04, 32'h02);
    @(posedge clk_sys) #1 chk(pingpongReset, 1);
    chk(packetDisable | moduleEnable, 0);
  endtask
  task t_host;
    int n;
    // A token is only started while the busy indication is clear.
    @(posedge clk_sys) tokenActive <= 1;
    wr(8'h04, 32'h08);
    rd(8'h04, 32'hA8);
    @(posedge clk_sys) tokenActive <= 0;
    wr(8'h04, 32'h18);
    repeat (8) @(posedge clk_sys);
    #1 chk(busResetDrive, 1);
    rd(8'h04, 32'h58);
    wr(8'h04, 32'h0C);
    // The resume hold is cut short here to keep the run brief.
    repeat (2) @(posedge clk_sys);
    #1 chk(resumeDrive, 1);
    wr(8'h04, 32'h08);
    n = 0;
    // A fixed span well past the end of packet keeps the count bounded.
    repeat (200) @(posedge clk_sys) #1 n += lsEopDrive;
    chk(n, 133);
    // A frame is far longer than this span, so no start of frame is due yet.
    wr(8'h04, 32'h09);
    n = 0;
    repeat (300) @(posedge clk_sys) #1 n += sofPulse;
    chk(n, 0);
    wr(8'h04, 32'h0);
    @(posedge clk_sys) #1 chk(hostMode, 0);
  endtask
  task summarize;
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 0;
    t_regs();
    t_fifo();
    t_dev();
    t_host();
    summarize();
  end
endmodule
